//--- verilog/sfm_pkg.sv
// Purpose: shared constants of the sector formatter mode and status registers
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: each register holds at most 8 bits in the low lane of a 32-bit word
package sfm_pkg;
   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   // register indices (byte address is four times these)
   localparam logic [7:0] IDX_MODE = 8'h4f;
   localparam logic [7:0] IDX_SYNC_LIMIT = 8'h70;
   localparam logic [7:0] IDX_VEC_LOW = 8'h71;
   localparam logic [7:0] IDX_VEC_MID = 8'h72;
   localparam logic [7:0] IDX_VEC_HIGH = 8'h73;
   localparam logic [7:0] IDX_VEC_PATTERN = 8'h74;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
   // mode control field positions
   localparam int MODE_FMT_RESET = 0;
   localparam int MODE_HOST_EN = 1;
   localparam int MODE_DISK_EN = 2;
   localparam int MODE_PULLUP_DIS = 3;
   localparam int MODE_DECODE_SEL = 4;
   localparam int MODE_ACTIVE_LOW = 5;
   localparam int MODE_MERGE = 6;
   // reset values, write mask and read mask
   localparam logic [7:0] MODE_RESET_VAL = 8'h01;
   localparam logic [7:0] MODE_WRITE_MASK = 8'h7f;
   localparam logic [7:0] SYNC_LIMIT_RESET_VAL = 8'h00;
   localparam logic [7:0] VEC_HIGH_MASK = 8'h3f;
   // interrupt status bits
   localparam int IRQ_W = 2;
   localparam int ST_SYNC_TIMEOUT = 0;
   localparam int ST_VEC_LOADED = 1;
   localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 2'h0;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // synchronization timer states
   typedef enum logic {
      TMR_IDLE = 1'b0,
      TMR_RUN = 1'b1
   } sfm_timer_e;
endpackage

//--- verilog/sfm_irq_drv.sv
// Purpose: drives one interrupt pin with polarity and open-drain options
// Assumes: all inputs come from flops on aclk
// Notes: outputs are registered, one cycle behind the inputs
`timescale 1ns/1ps
module sfm_irq_drv (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic drive_en,
   input wire logic level,
   input wire logic active_low,
   input wire logic pullup_dis,
   output logic pin_o,
   output logic pin_oe,
   output logic pullup_en
);
   // pin driver; active high always drives hard
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
         pullup_en <= 1'b1;
      end
      else
      begin
         pullup_en <= ~pullup_dis; // [R8]
         if (!drive_en)
         begin
            // pin released, nothing driven
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
         end
         else if (!active_low)
         begin
            // open drain cannot signal high, so it is overridden
            pin_o <= level; // [R11] [R12]
            pin_oe <= 1'b1;
         end
         else if (pullup_dis)
         begin
            // shared line: only pull low, never drive high
            pin_o <= 1'b0; // [R8]
            pin_oe <= level;
         end
         else
         begin
            pin_o <= ~level; // [R11]
            pin_oe <= 1'b1;
         end
      end
   end

   open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
      drive_en && active_low && pullup_dis |=> !pin_o && !pullup_en && pin_oe == $past(level))
      else $error("open drain pin drives high or keeps pull-up");
   high_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      drive_en && !active_low |=> pin_oe && pin_o == $past(level))
      else $error("active high pin not driven to level");
endmodule

//--- verilog/sfm_mode_ctl.sv
// Purpose: mode control, sync limit timer and vector registers of the formatter
// Assumes: AXI4-Lite master, one write and one read in flight at most
// Notes: sequencer-side inputs come from logic on aclk and are not resynchronized
// Function
// R1 - hardware reset clears mode except reset bit
// R2 - reset bit set halts all formatter operations
// R3 - software reset initializes formatter register groups
// R4 - in reset: gates off, data pin released
// R5 - reset lasts until software clears the bit
// R6 - host pin driven only when bit 1
// R7 - disk pin driven only when bit 2
// R8 - bit 3 removes pull-ups, pins open drain; here active high pins stay driven hard
// R9 - bit 4 picks SCSI window 40h or 60h
// R10 - no SCSI window until mode written after reset
// R11 - bit 5 set means active low pins
// R12 - active high pins always driven actively
// R13 - bit 6 merges host interrupt onto disk pin
// R14 - sync limit accepts any value 0 to 255
// R15 - timer counts bytes, zero sets timeout error
// R16 - limit read shows running count while active
// R17 - vector address: three bytes, six-bit high byte
// R18 - error pattern read only, cleared at reset
// R19 - reserved bits read zero, writes ignored
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sfm_mode_ctl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sfm_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [sfm_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [sfm_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [sfm_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic host_irq_src,
   input wire logic disk_irq_src,
   input wire logic read_gate_req,
   input wire logic write_gate_req,
   input wire logic nrz_data_req,
   input wire logic nrz_drive_req,
   input wire logic sync_timer_start,
   input wire logic sync_found,
   input wire logic byte_tick,
   input wire logic vec_load,
   input wire logic [21:0] vec_addr_in,
   input wire logic [7:0] vec_pattern_in,
   output logic fmt_halt,
   output logic fmt_init,
   output logic read_gate,
   output logic write_gate,
   output logic nrz_data_o,
   output logic nrz_data_oe,
   output logic host_irq_pin_o,
   output logic host_irq_pin_oe,
   output logic host_irq_pullup_en,
   output logic disk_irq_pin_o,
   output logic disk_irq_pin_oe,
   output logic disk_irq_pullup_en,
   output logic scsi_win_40_en,
   output logic scsi_win_60_en,
   output logic sync_timeout_err,
   output logic irq
);
   // register index from a byte address
   function automatic logic [7:0] idx_of(input logic [sfm_pkg::ADDR_W-1:0] a);
      return a[9:2];
   endfunction

   // true for every index this block answers
   function automatic logic is_mapped(input logic [7:0] idx);
      case (idx)
         sfm_pkg::IDX_MODE, sfm_pkg::IDX_SYNC_LIMIT, sfm_pkg::IDX_VEC_LOW,
         sfm_pkg::IDX_VEC_MID, sfm_pkg::IDX_VEC_HIGH, sfm_pkg::IDX_VEC_PATTERN,
         sfm_pkg::IDX_IRQ_STATUS, sfm_pkg::IDX_IRQ_MASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   logic [7:0] mode; // mode control register
   logic [7:0] sync_limit; // programmed byte-count limit
   logic [7:0] sync_count; // running count
   sfm_pkg::sfm_timer_e tmr_state; // sync timer state
   logic [7:0] vec_low; // vector address low byte
   logic [7:0] vec_mid; // vector address middle byte
   logic [5:0] vec_high; // vector address high six bits
   logic [7:0] vec_pattern; // vector error pattern
   logic [sfm_pkg::IRQ_W-1:0] irq_status; // sticky events
   logic [sfm_pkg::IRQ_W-1:0] irq_mask; // event enables
   logic decode_armed; // mode written since formatter reset
   logic [7:0] aw_idx; // held write index
   logic aw_held; // write address waiting
   logic [7:0] w_byte; // held write data, low lane
   logic w_lane; // low byte lane enabled
   logic w_held; // write data waiting
   logic [7:0] ar_idx; // held read index
   logic ar_held; // read address waiting
   logic do_write; // perform held write this cycle
   logic do_read; // perform held read this cycle
   logic wr_mode; // write strobe for mode control
   logic ev_sync_timeout; // timer reached zero this cycle
   logic [sfm_pkg::IRQ_W-1:0] ev_set; // events this cycle
   logic [sfm_pkg::IRQ_W-1:0] ev_clr; // read-clear of status
   logic [7:0] sync_view; // value shown at the limit register
   logic [7:0] next_rbyte; // read data before registering

   assign do_write = aw_held & w_held & ~bvalid;
   assign do_read = ar_held & ~rvalid;
   assign wr_mode = do_write & w_lane & (aw_idx == sfm_pkg::IDX_MODE);

   // write address channel; one write in flight
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         aw_idx <= 8'h00;
      end
      else if (awvalid && awready)
      begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         aw_idx <= idx_of(awaddr);
      end
      else
      begin
         if (do_write)
            aw_held <= 1'b0;
         // reopen only once the previous answer is gone
         awready <= ~aw_held & ~bvalid;
      end
   end

   // write data channel, taken independently of the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready <= 1'b0;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         wready <= 1'b0;
         w_held <= 1'b1;
         w_byte <= wdata[7:0];
         w_lane <= wstrb[0];
      end
      else
      begin
         if (do_write)
            w_held <= 1'b0;
         wready <= ~w_held & ~bvalid;
      end
   end

   // write response, one cycle after both halves arrive
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= sfm_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         // writes to read-only registers are dropped but answered okay
         bresp <= is_mapped(aw_idx) ? sfm_pkg::RESP_OKAY : sfm_pkg::RESP_DECERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // mode control; only software changes it after reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode <= sfm_pkg::MODE_RESET_VAL; // [R1]
      else if (wr_mode)
         mode <= w_byte & sfm_pkg::MODE_WRITE_MASK; // [R5] [R19]
   end

   // software reset pulse and the decode arming flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fmt_init <= 1'b0;
         decode_armed <= 1'b0;
      end
      else
      begin
         // every write with the reset bit set re-initializes the group
         fmt_init <= wr_mode & w_byte[sfm_pkg::MODE_FMT_RESET]; // [R3]
         if (wr_mode)
            decode_armed <= ~w_byte[sfm_pkg::MODE_FMT_RESET]; // [R10]
      end
   end

   // formatter halt and disk-side gates
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fmt_halt <= 1'b1;
         read_gate <= 1'b0;
         write_gate <= 1'b0;
         nrz_data_o <= 1'b0;
         nrz_data_oe <= 1'b0;
      end
      else
      begin
         fmt_halt <= mode[sfm_pkg::MODE_FMT_RESET]; // [R2]
         read_gate <= read_gate_req & ~mode[sfm_pkg::MODE_FMT_RESET]; // [R4]
         write_gate <= write_gate_req & ~mode[sfm_pkg::MODE_FMT_RESET]; // [R4]
         nrz_data_o <= nrz_data_req & ~mode[sfm_pkg::MODE_FMT_RESET];
         nrz_data_oe <= nrz_drive_req & ~mode[sfm_pkg::MODE_FMT_RESET]; // [R4]
      end
   end

   // SCSI register window select
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scsi_win_40_en <= 1'b0;
         scsi_win_60_en <= 1'b0;
      end
      else
      begin
         scsi_win_40_en <= decode_armed & mode[sfm_pkg::MODE_DECODE_SEL]; // [R9] [R10]
         scsi_win_60_en <= decode_armed & ~mode[sfm_pkg::MODE_DECODE_SEL]; // [R9] [R10]
      end
   end

   // sync limit register; any byte value is legal
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sync_limit <= sfm_pkg::SYNC_LIMIT_RESET_VAL;
      else if (do_write && w_lane && aw_idx == sfm_pkg::IDX_SYNC_LIMIT)
         sync_limit <= w_byte; // [R14]
   end

   // zero reached on this byte time; a start at zero times out on the first byte
   assign ev_sync_timeout = (tmr_state == sfm_pkg::TMR_RUN) & byte_tick & ~sync_found
      & (sync_count <= 8'h01) & ~mode[sfm_pkg::MODE_FMT_RESET];

   // sync timer, stopped and cleared while the formatter is in reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn || mode[sfm_pkg::MODE_FMT_RESET])
      begin
         tmr_state <= sfm_pkg::TMR_IDLE; // [R2]
         sync_count <= 8'h00;
      end
      else
      begin
         case (tmr_state)
            sfm_pkg::TMR_IDLE:
            begin
               if (sync_timer_start)
               begin
                  sync_count <= sync_limit;
                  tmr_state <= sfm_pkg::TMR_RUN;
               end
            end
            sfm_pkg::TMR_RUN:
            begin
               if (sync_found)
                  tmr_state <= sfm_pkg::TMR_IDLE;
               else if (ev_sync_timeout)
               begin
                  sync_count <= 8'h00; // [R15]
                  tmr_state <= sfm_pkg::TMR_IDLE;
               end
               else if (byte_tick)
                  sync_count <= sync_count - 8'h01; // [R15]
            end
            default: tmr_state <= sfm_pkg::TMR_IDLE;
         endcase
      end
   end

   // timeout error pulse toward the error register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sync_timeout_err <= 1'b0;
      else
         sync_timeout_err <= ev_sync_timeout; // [R15]
   end

   // running count while active, programmed limit otherwise
   assign sync_view = (tmr_state == sfm_pkg::TMR_RUN) ? sync_count : sync_limit; // [R16]

   // vector registers, loaded by the correction path, cleared by any reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn || mode[sfm_pkg::MODE_FMT_RESET])
      begin
         vec_low <= 8'h00; // [R3]
         vec_mid <= 8'h00;
         vec_high <= 6'h00;
         vec_pattern <= 8'h00; // [R18]
      end
      else if (vec_load)
      begin
         vec_low <= vec_addr_in[7:0]; // [R17]
         vec_mid <= vec_addr_in[15:8];
         vec_high <= vec_addr_in[21:16];
         vec_pattern <= vec_pattern_in;
      end
   end

   // event sources and read-clear of the status register
   assign ev_set = {vec_load & ~mode[sfm_pkg::MODE_FMT_RESET], ev_sync_timeout};
   assign ev_clr = (do_read && ar_idx == sfm_pkg::IDX_IRQ_STATUS) ? irq_status
      : {sfm_pkg::IRQ_W{1'b0}};

   // sticky status; an event in the clearing cycle survives
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= sfm_pkg::IRQ_RESET_VAL;
      else
         irq_status <= (irq_status & ~ev_clr) | ev_set;
   end

   // interrupt mask and level output
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_mask <= sfm_pkg::IRQ_RESET_VAL;
         irq <= 1'b0;
      end
      else
      begin
         if (do_write && w_lane && aw_idx == sfm_pkg::IDX_IRQ_MASK)
            irq_mask <= w_byte[sfm_pkg::IRQ_W-1:0]; // [R19]
         irq <= |(irq_status & irq_mask);
      end
   end

   // read data select; reserved bits stay zero
   always_comb
   begin
      case (ar_idx)
         sfm_pkg::IDX_MODE: next_rbyte = mode;
         sfm_pkg::IDX_SYNC_LIMIT: next_rbyte = sync_view; // [R16]
         sfm_pkg::IDX_VEC_LOW: next_rbyte = vec_low;
         sfm_pkg::IDX_VEC_MID: next_rbyte = vec_mid;
         sfm_pkg::IDX_VEC_HIGH: next_rbyte = {2'h0, vec_high} & sfm_pkg::VEC_HIGH_MASK; // [R17]
         sfm_pkg::IDX_VEC_PATTERN: next_rbyte = vec_pattern; // [R18]
         sfm_pkg::IDX_IRQ_STATUS: next_rbyte = {6'h00, irq_status};
         sfm_pkg::IDX_IRQ_MASK: next_rbyte = {6'h00, irq_mask};
         default: next_rbyte = 8'h00;
      endcase
   end

   // read address and data channels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         ar_held <= 1'b0;
         ar_idx <= 8'h00;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= sfm_pkg::RESP_OKAY;
      end
      else
      begin
         if (arvalid && arready)
         begin
            arready <= 1'b0;
            ar_held <= 1'b1;
            ar_idx <= idx_of(araddr);
         end
         else
            arready <= ~ar_held & ~rvalid;
         if (do_read)
         begin
            ar_held <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, next_rbyte}; // [R19]
            rresp <= is_mapped(ar_idx) ? sfm_pkg::RESP_OKAY : sfm_pkg::RESP_DECERR;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // host pin gives way entirely in merge mode
   sfm_irq_drv u_host_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .drive_en(mode[sfm_pkg::MODE_HOST_EN] & ~mode[sfm_pkg::MODE_MERGE]), // [R6] [R13]
      .level(host_irq_src),
      .active_low(mode[sfm_pkg::MODE_ACTIVE_LOW]),
      .pullup_dis(mode[sfm_pkg::MODE_PULLUP_DIS]),
      .pin_o(host_irq_pin_o),
      .pin_oe(host_irq_pin_oe),
      .pullup_en(host_irq_pullup_en)
   );

   // disk pin carries both sources when merged
   sfm_irq_drv u_disk_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .drive_en(mode[sfm_pkg::MODE_DISK_EN]), // [R7]
      .level(disk_irq_src | (mode[sfm_pkg::MODE_MERGE] & host_irq_src)), // [R13]
      .active_low(mode[sfm_pkg::MODE_ACTIVE_LOW]),
      .pullup_dis(mode[sfm_pkg::MODE_PULLUP_DIS]),
      .pin_o(disk_irq_pin_o),
      .pin_oe(disk_irq_pin_oe),
      .pullup_en(disk_irq_pullup_en)
   );

   // running timer at count one taking a byte time without sync found
   sequence sync_last_byte_s;
      tmr_state == sfm_pkg::TMR_RUN && sync_count == 8'h01 && byte_tick && !sync_found
         && !mode[sfm_pkg::MODE_FMT_RESET];
   endsequence

   sequence sync_start_s;
      tmr_state == sfm_pkg::TMR_IDLE && sync_timer_start && !mode[sfm_pkg::MODE_FMT_RESET];
   endsequence

   reset_value_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
      !$past(aresetn) |-> mode == sfm_pkg::MODE_RESET_VAL && fmt_halt)
      else $error("mode not at reset value after reset");
   halt_gates_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
      mode[sfm_pkg::MODE_FMT_RESET] |=> fmt_halt && !read_gate && !write_gate && !nrz_data_oe)
      else $error("gates active during formatter reset");
   halt_timer_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
      mode[sfm_pkg::MODE_FMT_RESET] |=> tmr_state == sfm_pkg::TMR_IDLE && !sync_timeout_err)
      else $error("sync timer runs during formatter reset");
   host_pin_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
      !mode[sfm_pkg::MODE_HOST_EN] || mode[sfm_pkg::MODE_MERGE] |=> !host_irq_pin_oe)
      else $error("host pin driven while disabled or merged");
   disk_pin_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
      !mode[sfm_pkg::MODE_DISK_EN] |=> !disk_irq_pin_oe)
      else $error("disk pin driven while disabled");
   merge_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
      mode[sfm_pkg::MODE_MERGE] && mode[sfm_pkg::MODE_DISK_EN] && !mode[sfm_pkg::MODE_ACTIVE_LOW]
      && host_irq_src |=> disk_irq_pin_o && disk_irq_pin_oe)
      else $error("host interrupt not merged onto disk pin");
   window_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
      decode_armed |=> scsi_win_40_en == $past(mode[sfm_pkg::MODE_DECODE_SEL])
      && scsi_win_60_en == !$past(mode[sfm_pkg::MODE_DECODE_SEL]))
      else $error("wrong SCSI window decoded");
   window_block_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      mode[sfm_pkg::MODE_FMT_RESET] |=> !scsi_win_40_en && !scsi_win_60_en)
      else $error("SCSI window decoded during formatter reset");
   sync_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
      sync_last_byte_s |=> sync_timeout_err && tmr_state == sfm_pkg::TMR_IDLE
      ##1 !sync_timeout_err)
      else $error("sync timeout not flagged at zero");
   sync_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
      sync_start_s |=> sync_view == $past(sync_limit) && tmr_state == sfm_pkg::TMR_RUN)
      else $error("running count not loaded from limit");
endmodule

//--- tb/sfm_host_model.sv
// Purpose: register-port master model for the local microcontroller
// Assumes: one write and one read in flight at most, byte address = 4 * index
// Notes: each channel holds its payload until its own ready is sampled high
`timescale 1ns/1ps
module sfm_host_model (
   input wire logic aclk,
   output logic [9:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   output logic bready,
   output logic [9:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   output logic rready
);
   // idle bus at time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // full byte written, any 8-bit value accepted
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic aw;
      logic w;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      // address and data may be taken at different edges
      while (!(aw && w))
      begin
         @(posedge aclk);
         if (!aw && awready === 1'b1)
         begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1)
         begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   // read; data is judged by the bench watcher at the rvalid edge
   task automatic rd(input logic [7:0] idx);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench of the formatter mode and status registers
// Assumes: host model drives the register port, bench drives sequencer inputs
// Notes: read results are queued by the caller and judged by a watcher
`timescale 1ns/1ps
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic host_irq_src = 1'b0, disk_irq_src = 1'b0, read_gate_req = 1'b1, write_gate_req = 1'b1;
   logic nrz_data_req = 1'b1, nrz_drive_req = 1'b1, sync_timer_start = 1'b0, sync_found = 1'b0;
   logic byte_tick = 1'b0, vec_load = 1'b0;
   logic [21:0] vec_addr_in = 22'h0;
   logic [7:0] vec_pattern_in = 8'h0;
   logic fmt_halt, fmt_init, read_gate, write_gate, nrz_data_o, nrz_data_oe, irq;
   logic host_irq_pin_o, host_irq_pin_oe, host_irq_pullup_en, scsi_win_40_en, scsi_win_60_en;
   logic disk_irq_pin_o, disk_irq_pin_oe, disk_irq_pullup_en, sync_timeout_err;
   int fails = 0;
   int comparisons = 0;
   int tmo_cnt = 0, init_cnt = 0;
   logic [33:0] exp_q[$]; // {rresp, rdata} notes
   logic [7:0] lim;
   logic [21:0] va;
   logic [7:0] vp;
   always #5 aclk = ~aclk;
   sfm_mode_ctl dut_u (.*);
   sfm_host_model host_u (.*);
   task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [33:0] okv(input logic [7:0] b);
      return {sfm_pkg::RESP_OKAY, 24'h0, b};
   endfunction
   task automatic rd_exp(input logic [7:0] idx, input logic [33:0] e);
      exp_q.push_back(e);
      host_u.rd(idx);
   endtask
   // pins lag the mode register by a few edges
   task automatic settle;
      repeat (3) @(posedge aclk);
      #1;
   endtask
   task automatic tick;
      @(posedge aclk);
      byte_tick <= 1'b1;
      @(posedge aclk);
      byte_tick <= 1'b0;
   endtask
   task automatic stop_test;
      if (fails == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watcher: oldest note against each read response
   always @(posedge aclk)
      if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
         check("read", {rresp, rdata}, exp_q.pop_front());
   // one-cycle pulses are counted, every write answer is judged
   always @(posedge aclk)
   begin
      if (sync_timeout_err === 1'b1)
         tmo_cnt <= tmo_cnt + 1;
      if (fmt_init === 1'b1)
         init_cnt <= init_cnt + 1;
      if (bvalid === 1'b1 && bready === 1'b1)
         check("bresp", bresp, sfm_pkg::RESP_OKAY);
   end
   // watchdog, far beyond the few hundred cycles the tests take
   initial
   begin
      #200000;
      fails++;
      stop_test();
   end
   initial
   begin
      void'($urandom(32'hd69a77a2));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      check("halt", fmt_halt, 1);
      check("gates", {read_gate, write_gate, nrz_data_oe}, 0);
      check("win", {scsi_win_40_en, scsi_win_60_en}, 0);
      rd_exp(sfm_pkg::IDX_MODE, okv(8'h01));
      host_u.wr(sfm_pkg::IDX_MODE, 8'h92); // reserved bit 7 set on purpose
      rd_exp(sfm_pkg::IDX_MODE, okv(8'h12));
      host_irq_src <= 1'b1;
      settle();
      check("run", {fmt_halt, read_gate, nrz_data_o}, 3'b011);
      check("win", {scsi_win_40_en, scsi_win_60_en}, 2'b10);
      check("host", {host_irq_pin_o, host_irq_pin_oe}, 2'b11);
      check("disk", disk_irq_pin_oe, 0);
      host_u.wr(sfm_pkg::IDX_MODE, 8'h0e);
      settle();
      check("hostod", {host_irq_pin_o, host_irq_pin_oe, host_irq_pullup_en}, 3'b110);
      check("disk", {disk_irq_pin_o, disk_irq_pin_oe, disk_irq_pullup_en}, 3'b010);
      check("win", {scsi_win_40_en, scsi_win_60_en}, 2'b01);
      host_u.wr(sfm_pkg::IDX_MODE, 8'h2e);
      settle();
      check("hostlow", {host_irq_pin_o, host_irq_pin_oe}, 2'b01);
      host_u.wr(sfm_pkg::IDX_MODE, 8'h46);
      settle();
      check("merge", {host_irq_pin_oe, disk_irq_pin_o, disk_irq_pin_oe}, 3'b011);
      host_irq_src <= 1'b0;
      // sync timer with a random small limit
      lim = 8'h01 + 8'($urandom % 4);
      host_u.wr(sfm_pkg::IDX_SYNC_LIMIT, lim);
      host_u.wr(sfm_pkg::IDX_IRQ_MASK, 8'h01);
      @(posedge aclk);
      sync_timer_start <= 1'b1;
      @(posedge aclk);
      sync_timer_start <= 1'b0;
      rd_exp(sfm_pkg::IDX_SYNC_LIMIT, okv(lim));
      repeat (lim - 1) tick();
      settle();
      check("early", tmo_cnt, 0);
      tick();
      settle();
      check("tmo", {tmo_cnt[1:0], irq}, 3'b011);
      rd_exp(sfm_pkg::IDX_IRQ_STATUS, okv(8'h01));
      rd_exp(sfm_pkg::IDX_SYNC_LIMIT, okv(lim));
      settle();
      check("irqclr", irq, 0);
      // vector registers, read only
      va = 22'($urandom);
      vp = 8'($urandom);
      @(posedge aclk);
      {vec_addr_in, vec_pattern_in, vec_load} <= {va, vp, 1'b1};
      @(posedge aclk);
      vec_load <= 1'b0;
      host_u.wr(sfm_pkg::IDX_VEC_LOW, ~va[7:0]);
      rd_exp(sfm_pkg::IDX_VEC_LOW, okv(va[7:0]));
      rd_exp(sfm_pkg::IDX_VEC_MID, okv(va[15:8]));
      rd_exp(sfm_pkg::IDX_VEC_HIGH, okv({2'b00, va[21:16]}));
      rd_exp(sfm_pkg::IDX_VEC_PATTERN, okv(vp));
      rd_exp(8'h80, {sfm_pkg::RESP_DECERR, 32'h0});
      // software formatter reset
      host_u.wr(sfm_pkg::IDX_MODE, 8'h01);
      settle();
      check("swrst", {fmt_halt, read_gate, write_gate, nrz_data_oe}, 4'b1000);
      check("win", {scsi_win_40_en, scsi_win_60_en}, 0);
      rd_exp(sfm_pkg::IDX_VEC_LOW, okv(8'h00));
      rd_exp(sfm_pkg::IDX_VEC_PATTERN, okv(8'h00));
      host_u.wr(sfm_pkg::IDX_MODE, 8'h00);
      settle();
      check("rearm", {fmt_halt, scsi_win_40_en, scsi_win_60_en}, 3'b001);
      check("init", init_cnt, 1);
      check("left", exp_q.size(), 0);
      stop_test();
   end
endmodule
